// file: rtl/lams_alarm_block.sv
// Per-channel alarm masks, live alarm status and interrupt request logic.
// Assumes detector inputs are synchronous to core_clk_i and a byte register port.
`timescale 1ns/1ps
module lams_alarm_block import lams_pkg::*; (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire lams_bus_req_t bus_req_i, // Register port request
  output logic [DW-1:0] rd_data_o, // Read data, cycle after the read strobe
  input wire lams_live_t [NCH-1:0] live_i, // Live detector levels
  input wire lams_evt_a_t [NCH-1:0] evt_a_i, // One-cycle transmit path events
  input wire lams_cond_b_t [NCH-1:0] cond_b_i, // Alarm and code levels
  input wire lams_evt_c_t [NCH-1:0] evt_c_i, // One-cycle error events
  output logic irq_o // Level interrupt request
);

  // ==========================================================================
  // Address decode
  // ==========================================================================

  // Block to channel: blocks 0..20 are channels 1..21, top block is channel 0
  function automatic logic [5:0] chan_of(input logic [AW-1:0] a);
    logic [4:0] blk;
    blk = a[AW-1:6];
    if (blk == CH0_BLOCK) begin
      chan_of = {1'b1, 5'h00};
    end else if (blk <= LAST_LOW_BLOCK) begin
      chan_of = {1'b1, 5'(blk + 5'h01)};
    end else begin
      chan_of = 6'h00;
    end
  endfunction

  logic [5:0] dec; // {hit, channel}
  logic dec_hit; // Address falls in a channel block
  logic [4:0] dec_ch; // Channel number
  logic [5:0] ofs; // Offset inside the block

  assign dec = chan_of(bus_req_i.addr);
  assign dec_hit = dec[5];
  assign dec_ch = dec[4:0];
  assign ofs = bus_req_i.addr[5:0];

  // ==========================================================================
  // Per-channel views, gathered for the read path and the request
  // ==========================================================================
  logic [DW-1:0] mask_a_all [NCH]; // Masks, one byte each
  logic [DW-1:0] mask_b_all [NCH];
  logic [DW-1:0] mask_c_all [NCH];
  logic [DW-1:0] es_all [NCH]; // Edge select bytes
  logic [DW-1:0] stat_all [NCH]; // Live status as read
  lams_live_t live_all [NCH]; // Registered live levels
  logic [DW-1:0] int_a_all [NCH]; // Latched interrupt bits
  logic [DW-1:0] int_b_all [NCH];
  logic [DW-1:0] int_c_all [NCH];
  logic [NCH-1:0] pend; // Channel has an unmasked latched bit

  // ==========================================================================
  // Channel copies
  // ==========================================================================
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic wr_me; // Write aimed at this channel
    logic [DW-1:0] mask_a_reg;
    logic [DW-1:0] mask_b_reg;
    logic [DW-1:0] mask_c_reg;
    logic [DW-1:0] edge_sel_reg;
    lams_live_t live_reg;
    logic [DW-1:0] src_a; // Latch sources, laid out as the masks
    logic [DW-1:0] src_b;
    logic [DW-1:0] src_c;
    logic [DW-1:0] any_a; // Both-edge choice per bit
    logic [DW-1:0] any_b;
    logic [DW-1:0] clr_a; // Write-one clears
    logic [DW-1:0] clr_b;
    logic [DW-1:0] clr_c;

    assign wr_me = bus_req_i.wr && dec_hit && (dec_ch == 5'(g));

    // Masks come up blocking so no source fires before software is ready
    always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
        mask_a_reg <= RST_MASK_A;
        mask_b_reg <= RST_MASK_B;
        mask_c_reg <= RST_MASK_C;
      end else if (wr_me) begin
        // Reserved mask bits are stored but gate nothing
        if (ofs == OFS_MASK_A) begin
          mask_a_reg <= bus_req_i.wdata;
        end
        if (ofs == OFS_MASK_B) begin
          mask_b_reg <= bus_req_i.wdata;
        end
        if (ofs == OFS_MASK_C) begin
          mask_c_reg <= bus_req_i.wdata;
        end
      end
    end

    // Edge select byte; bit 7 reads as zero
    always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
        edge_sel_reg <= RST_ZERO;
      end else if (wr_me && (ofs == OFS_EDGE_SEL)) begin
        edge_sel_reg <= bus_req_i.wdata & USED_EDGE;
      end
    end

    // Live levels sampled once; status reads and edge detection share them
    always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
        live_reg <= '0;
      end else begin
        live_reg <= live_i[g];
      end
    end

    // Status byte: writes to it are ignored
    assign stat_all[g] = {live_reg.auto_loopback_active, 2'b00,
                          live_reg.driver_overcurrent_live,
                          live_reg.tx_clock_missing_live,
                          live_reg.tx_signal_loss_live,
                          live_reg.system_signal_loss_live,
                          live_reg.line_signal_loss_live};

    // Sources for the first latch byte: three pulses, five levels
    assign src_a = {evt_a_i[g].amplitude_overflow,
                    evt_a_i[g].tx_jitter_fifo_fault,
                    evt_a_i[g].rx_jitter_fifo_fault,
                    stat_all[g][4:0]};
    // System and line signal loss levels share one edge choice
    assign any_a = {3'b000, edge_sel_reg[ES_TOC], edge_sel_reg[ES_TCK],
                    edge_sel_reg[ES_TLOS], edge_sel_reg[ES_LOS],
                    edge_sel_reg[ES_LOS]};

    // Sources for the second latch byte: all levels
    assign src_b = {cond_b_i[g].system_alarm_ind, cond_b_i[g].line_alarm_ind,
                    cond_b_i[g].pattern_sync, 3'b000,
                    cond_b_i[g].inband_activate,
                    cond_b_i[g].inband_deactivate};
    assign any_b = {edge_sel_reg[ES_AIS], edge_sel_reg[ES_AIS],
                    edge_sel_reg[ES_PA], 3'b000, edge_sel_reg[ES_IB],
                    edge_sel_reg[ES_IB]};

    // Sources for the third latch byte: all pulses
    assign src_c = {2'b00, evt_c_i[g]};

    // Clears only on a write to the matching latch byte
    assign clr_a = (wr_me && (ofs == OFS_INT_A)) ? bus_req_i.wdata : RST_ZERO;
    assign clr_b = (wr_me && (ofs == OFS_INT_B)) ? bus_req_i.wdata : RST_ZERO;
    assign clr_c = (wr_me && (ofs == OFS_INT_C)) ? bus_req_i.wdata : RST_ZERO;

    // First latch byte
    lams_event_latch u_lat_a (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .src_i(src_a),
      .level_i(8'h1f),
      .any_edge_i(any_a),
      .used_i(8'hff),
      .clr_i(clr_a),
      .stat_o(int_a_all[g])
    );

    // Second latch byte
    lams_event_latch u_lat_b (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .src_i(src_b),
      .level_i(USED_B),
      .any_edge_i(any_b),
      .used_i(USED_B),
      .clr_i(clr_b),
      .stat_o(int_b_all[g])
    );

    // Third latch byte
    lams_event_latch u_lat_c (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .src_i(src_c),
      .level_i(8'h00),
      .any_edge_i(8'h00),
      .used_i(USED_C),
      .clr_i(clr_c),
      .stat_o(int_c_all[g])
    );

    assign mask_a_all[g] = mask_a_reg;
    assign mask_b_all[g] = mask_b_reg;
    assign mask_c_all[g] = mask_c_reg;
    assign es_all[g] = edge_sel_reg;
    assign live_all[g] = live_reg;

    // A mask bit of zero lets its latched bit through
    assign pend[g] = |((int_a_all[g] & ~mask_a_reg) |
                       (int_b_all[g] & ~mask_b_reg) |
                       (int_c_all[g] & ~mask_c_reg));
  end

  // ==========================================================================
  // Read path
  // ==========================================================================
  logic [DW-1:0] rd_val; // Byte selected by the address
  logic [DW-1:0] rd_data_reg;
  logic irq_reg;

  // Unmapped addresses read as zero rather than stalling the master
  always_comb begin
    rd_val = RST_ZERO;
    if (dec_hit) begin
      case (ofs)
        OFS_EDGE_SEL: rd_val = es_all[dec_ch];
        OFS_MASK_A: rd_val = mask_a_all[dec_ch];
        OFS_MASK_B: rd_val = mask_b_all[dec_ch];
        OFS_MASK_C: rd_val = mask_c_all[dec_ch];
        OFS_STAT: rd_val = stat_all[dec_ch];
        OFS_INT_A: rd_val = int_a_all[dec_ch];
        OFS_INT_B: rd_val = int_b_all[dec_ch];
        OFS_INT_C: rd_val = int_c_all[dec_ch];
        default: rd_val = RST_ZERO;
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rd_data_reg <= RST_ZERO;
    end else if (bus_req_i.rd) begin
      rd_data_reg <= rd_val;
    end else begin
      rd_data_reg <= RST_ZERO;
    end
  end

  assign rd_data_o = rd_data_reg;

  // ==========================================================================
  // Interrupt request
  // ==========================================================================

  // Registered to keep the pin glitch free; costs one cycle of latency
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |pend;
    end
  end

  assign irq_o = irq_reg;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);

  mask_reset_a: assert property (
    $past(srst_i) |-> (mask_a_all[0] == RST_MASK_A) && (mask_b_all[5] == RST_MASK_B)
      && (mask_c_all[21] == RST_MASK_C) && (irq_o == 1'b0))
    else $error("mask bytes not at reset values");

  chan_write_a: assert property (
    bus_req_i.wr && (bus_req_i.addr == {LAST_LOW_BLOCK, OFS_MASK_B})
      |=> mask_b_all[21] == $past(bus_req_i.wdata))
    else $error("channel 21 mask write missed");

  chan0_read_a: assert property (
    bus_req_i.rd && (bus_req_i.addr == {CH0_BLOCK, OFS_MASK_A})
      |=> rd_data_o == $past(mask_a_all[0]))
    else $error("channel 0 mask read wrong");

  status_read_a: assert property (
    bus_req_i.rd && (bus_req_i.addr == {CH0_BLOCK, OFS_STAT}) && !$past(srst_i)
      |=> (rd_data_o[ST_AUTOLP] == $past(live_i[0].auto_loopback_active, 2))
        && (rd_data_o[6:5] == 2'b00)
        && (rd_data_o[MA_TCK] == $past(live_i[0].tx_clock_missing_live, 2))
        && (rd_data_o[MA_LLOS] == $past(live_i[0].line_signal_loss_live, 2)))
    else $error("status byte does not follow live levels");

  rise_latch_a: assert property (
    $rose(live_all[0].driver_overcurrent_live) |=> int_a_all[0][MA_TOC])
    else $error("rising level did not latch");

  // Watched on the channel whose edge choice software actually exercises
  fall_ignored_a: assert property (
    $fell(live_all[3].driver_overcurrent_live) && !es_all[3][ES_TOC]
      && !int_a_all[3][MA_TOC] |=> !int_a_all[3][MA_TOC])
    else $error("falling level latched without edge select");

  fall_latch_a: assert property (
    $fell(live_all[3].driver_overcurrent_live) && es_all[3][ES_TOC]
      |=> int_a_all[3][MA_TOC])
    else $error("falling level missed with edge select");

  pulse_set_a: assert property (
    evt_a_i[0].amplitude_overflow |=> int_a_all[0][MA_AMP])
    else $error("amplitude event lost");

  reserved_zero_a: assert property (
    (int_b_all[0][4:2] == 3'b000) && (int_c_all[0][7:6] == 2'b00))
    else $error("reserved latch bits set");

  unmasked_irq_a: assert property (
    int_c_all[11][0] && !mask_c_all[11][0] |=> irq_o)
    else $error("unmasked latched bit gave no request");

  masked_quiet_a: assert property (
    !(|pend) |=> !irq_o)
    else $error("request without unmasked latched bit");

endmodule

// file: rtl/lams_event_latch.sv
// Byte-wide sticky event latch with per-bit edge choice and write-one clear.
// Assumes sources are synchronous to core_clk_i.
`timescale 1ns/1ps
module lams_event_latch import lams_pkg::*; (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [DW-1:0] src_i, // Source bits
  input wire logic [DW-1:0] level_i, // 1: source is a level, 0: a pulse
  input wire logic [DW-1:0] any_edge_i, // 1: both edges of a level set the bit
  input wire logic [DW-1:0] used_i, // 0: reserved bit, always reads 0
  input wire logic [DW-1:0] clr_i, // One-cycle clear, one bit each
  output logic [DW-1:0] stat_o
);

  // ==========================================================================
  // State
  // ==========================================================================
  logic [DW-1:0] prev_reg; // Source one cycle ago
  logic [DW-1:0] stat_reg; // Latched bits
  logic [DW-1:0] hit; // Bits that see their event now
  logic [DW-1:0] stat_next;

  // Previous source value for edge detection
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      prev_reg <= RST_ZERO;
    end else begin
      prev_reg <= src_i;
    end
  end

  // Set wins over a clear in the same cycle, so no event is lost
  always_comb begin
    hit = used_i & ((level_i & ((any_edge_i & (src_i ^ prev_reg)) |
                                (~any_edge_i & src_i & ~prev_reg))) |
                    (~level_i & src_i));
    stat_next = (stat_reg & ~clr_i) | hit;
  end

  // Latched bits
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      stat_reg <= RST_ZERO;
    end else begin
      stat_reg <= stat_next;
    end
  end

  assign stat_o = stat_reg;

endmodule

// file: rtl/lams_pkg.sv
// Package for the per-channel line alarm mask and status block.
// Assumes one core clock, a synchronous reset and a plain byte register port.
package lams_pkg;

  // ==========================================================================
  // Sizes
  // ==========================================================================
  localparam int NCH = 22; // Channel 0 plus channels 1 to 21
  localparam int AW = 11; // Register address width
  localparam int DW = 8; // Register data width

  // ==========================================================================
  // Address map: address = {block, offset}
  // ==========================================================================
  localparam logic [4:0] CH0_BLOCK = 5'h1f; // High block that holds channel 0
  localparam logic [4:0] LAST_LOW_BLOCK = 5'h14; // Block of channel 21
  localparam logic [5:0] OFS_EDGE_SEL = 6'h1a;
  localparam logic [5:0] OFS_MASK_A = 6'h1b;
  localparam logic [5:0] OFS_MASK_B = 6'h1c;
  localparam logic [5:0] OFS_MASK_C = 6'h1d;
  localparam logic [5:0] OFS_STAT = 6'h1e;
  localparam logic [5:0] OFS_INT_A = 6'h20;
  localparam logic [5:0] OFS_INT_B = 6'h21;
  localparam logic [5:0] OFS_INT_C = 6'h22;

  // ==========================================================================
  // Values after reset and implemented bits
  // ==========================================================================
  localparam logic [7:0] RST_MASK_A = 8'hff;
  localparam logic [7:0] RST_MASK_B = 8'hef;
  localparam logic [7:0] RST_MASK_C = 8'h3f;
  localparam logic [7:0] RST_ZERO = 8'h00; // Status, edge select, latches
  localparam logic [7:0] USED_EDGE = 8'h7f;
  localparam logic [7:0] USED_B = 8'he3;
  localparam logic [7:0] USED_C = 8'h3f;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int MA_AMP = 7;
  localparam int MA_TXJ = 6;
  localparam int MA_RXJ = 5;
  localparam int MA_TOC = 4; // Also the live status position
  localparam int MA_TCK = 3;
  localparam int MA_TLOS = 2;
  localparam int MA_SLOS = 1;
  localparam int MA_LLOS = 0;
  localparam int ST_AUTOLP = 7;
  localparam int ES_AIS = 6;
  localparam int ES_PA = 5;
  localparam int ES_TOC = 4;
  localparam int ES_TCK = 3;
  localparam int ES_TLOS = 2;
  localparam int ES_LOS = 1;
  localparam int ES_IB = 0;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic wr;
    logic rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } lams_bus_req_t;

  typedef struct packed {
    logic auto_loopback_active;
    logic driver_overcurrent_live;
    logic tx_clock_missing_live;
    logic tx_signal_loss_live;
    logic system_signal_loss_live;
    logic line_signal_loss_live;
  } lams_live_t;

  typedef struct packed {
    logic amplitude_overflow;
    logic tx_jitter_fifo_fault;
    logic rx_jitter_fifo_fault;
  } lams_evt_a_t;

  typedef struct packed {
    logic system_alarm_ind;
    logic line_alarm_ind;
    logic pattern_sync;
    logic inband_activate;
    logic inband_deactivate;
  } lams_cond_b_t;

  typedef struct packed {
    logic system_bipolar_violation;
    logic line_bipolar_violation;
    logic system_excess_zero;
    logic line_excess_zero;
    logic pattern_bit_error;
    logic error_counter_overflow;
  } lams_evt_c_t;

endpackage

// file: tb/test_line_alarm_mask_status.sv
// Self-checking bench for the per-channel alarm mask and status block.
// Assumes the bench alone drives every port; no far-side model is used.
`timescale 1ns/1ps
module test_line_alarm_mask_status import lams_pkg::*;;
  // ==========================================================================
  // Stimulus and observed signals
  // ==========================================================================
  logic core_clk_i = 1'b0; // 10 MHz core clock
  logic srst_i = 1'b1; // Held for two cycles at start
  lams_bus_req_t bus_req_i; // Register port request
  logic [DW-1:0] rd_data_o; // Read data seen
  lams_live_t [NCH-1:0] live_i; // Live detector levels
  lams_evt_a_t [NCH-1:0] evt_a_i; // Transmit path pulses
  lams_cond_b_t [NCH-1:0] cond_b_i; // Alarm levels
  lams_evt_c_t [NCH-1:0] evt_c_i; // Error pulses
  logic irq_o; // Interrupt request seen
  int fails = 0; // Mismatch count
  int n_compared = 0; // Comparison count
  int cycles = 0; // Cycle counter for the hang guard
  logic [DW-1:0] rd; // Last read value
  always #50 core_clk_i = ~core_clk_i;
  lams_alarm_block u_dut (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .bus_req_i(bus_req_i),
    .rd_data_o(rd_data_o), .live_i(live_i), .evt_a_i(evt_a_i),
    .cond_b_i(cond_b_i), .evt_c_i(evt_c_i), .irq_o(irq_o));
  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  // Verdict; every run ends here
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask
  // Block base of a channel: channel 0 sits in the high block
  function automatic logic [AW-1:0] base(input int ch);
    logic [4:0] blk;
    blk = (ch == 0) ? CH0_BLOCK : 5'(ch - 1);
    return {blk, 6'h00};
  endfunction
  task automatic wr(input logic [AW-1:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    bus_req_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk_i);
    bus_req_i <= '0;
  endtask
  // Data stands only in the cycle after the strobe, sampled once settled
  task automatic rdreg(input logic [AW-1:0] a);
    @(posedge core_clk_i);
    bus_req_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk_i);
    bus_req_i <= '0;
    #1 rd = rd_data_o;
  endtask
  // Drive one source bit, mapped from its latch bit position
  task automatic drive(input int ch, input int grp, input int b, input logic v);
    @(posedge core_clk_i);
    if (grp == 0 && b >= 5) evt_a_i[ch][b-5] <= v;
    else if (grp == 0) live_i[ch][b] <= v;
    else if (grp == 1 && b >= 5) cond_b_i[ch][b-3] <= v;
    else if (grp == 1) cond_b_i[ch][b] <= v;
    else evt_c_i[ch][b] <= v;
  endtask
  // Ends just past the edge so registered outputs are read once they settle
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Reset values of every channel copy
  task automatic t_reset();
    for (int ch = 0; ch < NCH; ch++) begin
      rdreg(base(ch) + 11'(OFS_MASK_A));
      check(rd, 8'hff, "mask a rst");
      rdreg(base(ch) + 11'(OFS_MASK_B));
      check(rd, 8'hef, "mask b rst");
      rdreg(base(ch) + 11'(OFS_MASK_C));
      check(rd, 8'h3f, "mask c rst");
      rdreg(base(ch) + 11'(OFS_STAT));
      check(rd, 8'h00, "stat rst");
    end
    check({7'h00, irq_o}, 8'h00, "irq rst");
    $display("test reset done");
  endtask
  // Independent copies, unmapped places, read-only status
  task automatic t_map();
    for (int ch = 0; ch < NCH; ch++) wr(base(ch) + 11'(OFS_MASK_A), 8'(ch + 8'h40));
    wr(11'h55b, 8'h00); // Unmapped block must not alias a channel
    for (int ch = 0; ch < NCH; ch++) begin
      rdreg(base(ch) + 11'(OFS_MASK_A));
      check(rd, 8'(ch + 8'h40), "mask copy");
      wr(base(ch) + 11'(OFS_MASK_A), 8'hff);
    end
    rdreg(11'h55b);
    check(rd, 8'h00, "unmapped block");
    wr(base(0) + 11'(OFS_MASK_B), 8'h10);
    rdreg(base(0) + 11'(OFS_MASK_B));
    check(rd, 8'h10, "mask b rw");
    wr(base(0) + 11'(OFS_MASK_C), 8'h2a);
    rdreg(base(0) + 11'(OFS_MASK_C));
    check(rd, 8'h2a, "mask c rw");
    // Read data must drop back to zero one cycle after it stands
    idle(1);
    check(rd_data_o, 8'h00, "read data one cycle");
    wr(base(0) + 11'(OFS_STAT), 8'hff);
    rdreg(base(0) + 11'(OFS_STAT));
    check(rd, 8'h00, "stat ro");
    $display("test map done");
  endtask
  // Live levels reach the right status bits; reserved bits stay 0
  task automatic t_status();
    @(posedge core_clk_i);
    live_i[5] <= 6'b110101;
    idle(2);
    rdreg(base(5) + 11'(OFS_STAT));
    check(rd, 8'h95, "stat live 1");
    @(posedge core_clk_i);
    live_i[5] <= 6'b001010;
    idle(2);
    rdreg(base(5) + 11'(OFS_STAT));
    check(rd, 8'h0a, "stat live 2");
    @(posedge core_clk_i);
    live_i[5] <= '0;
    idle(2);
    rdreg(base(5) + 11'(OFS_STAT));
    check(rd, 8'h00, "stat clear");
    $display("test status done");
  endtask
  // A masked source latches but stays quiet; unmasking raises the request
  task automatic gate(input int ch, input int grp, input int b);
    logic [AW-1:0] ma;
    logic [AW-1:0] la;
    ma = base(ch) + 11'(OFS_MASK_A) + 11'(grp);
    la = base(ch) + 11'(OFS_INT_A) + 11'(grp);
    wr(ma, 8'hff);
    drive(ch, grp, b, 1'b1);
    drive(ch, grp, b, 1'b0);
    idle(4);
    check({7'h00, irq_o}, 8'h00, "masked irq");
    rdreg(la);
    check(rd, 8'(1 << b), "latched bit");
    wr(ma, ~8'(1 << b));
    idle(2);
    check({7'h00, irq_o}, 8'h01, "unmasked irq");
    wr(la, 8'(1 << b));
    idle(2);
    check({7'h00, irq_o}, 8'h00, "irq after clear");
    wr(ma, 8'hff);
  endtask
  task automatic t_gates();
    for (int b = 0; b < 8; b++) gate(0, 0, b);
    for (int b = 0; b < 8; b++) if (b < 2 || b > 4) gate(21, 1, b);
    for (int b = 0; b < 6; b++) gate(11, 2, b);
    $display("test gates done");
  endtask
  // Falling edge latches only with the edge select bit set, in both latch bytes
  task automatic t_edge();
    for (int s = 0; s < 2; s++) begin
      wr(base(3) + 11'(OFS_EDGE_SEL), s ? 8'h50 : 8'h00);
      drive(3, 0, MA_TOC, 1'b1);
      drive(3, 1, 6, 1'b1);
      idle(4);
      wr(base(3) + 11'(OFS_INT_A), 8'h10);
      wr(base(3) + 11'(OFS_INT_B), 8'h40);
      drive(3, 0, MA_TOC, 1'b0);
      drive(3, 1, 6, 1'b0);
      idle(4);
      rdreg(base(3) + 11'(OFS_INT_A));
      check(rd, s ? 8'h10 : 8'h00, "fall edge");
      rdreg(base(3) + 11'(OFS_INT_B));
      check(rd, s ? 8'h40 : 8'h00, "fall edge alarm");
      wr(base(3) + 11'(OFS_INT_A), 8'h10);
      wr(base(3) + 11'(OFS_INT_B), 8'h40);
    end
    $display("test edge done");
  endtask
  // ==========================================================================
  // Main sequence and hang guard
  // ==========================================================================
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    bus_req_i = '0;
    live_i = '0;
    evt_a_i = '0;
    cond_b_i = '0;
    evt_c_i = '0;
    rd = '0;
    repeat (2) @(posedge core_clk_i);
    srst_i <= 1'b0;
    t_reset();
    t_map();
    t_status();
    t_gates();
    t_edge();
    final_report();
  end
endmodule
